// *** src/iod_pkg.sv ***
/*
 * Constants, types and a decode function for the integer opcode decoder.
 * Assumes a single core clock and instruction words already aligned.
 */
package iod_pkg;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int ROW_HI    = 31;
    localparam int ROW_LO    = 29;
    localparam int COL_HI    = 28;
    localparam int COL_LO    = 26;
    localparam int SRCA_HI   = 25;
    localparam int SRCA_LO   = 21;
    localparam int SRCB_HI   = 20;
    localparam int SRCB_LO   = 16;
    localparam int DEST_HI   = 15;
    localparam int DEST_LO   = 11;
    localparam int SHAMT_HI  = 10;
    localparam int SHAMT_LO  = 6;
    localparam int HINT_BIT  = 10;
    localparam int IMM_HI    = 15;
    localparam int IMM_LO    = 0;
    localparam int FROW_HI   = 5;
    localparam int FROW_LO   = 3;
    localparam int FCOL_HI   = 2;
    localparam int FCOL_LO   = 0;
    localparam int RIROW_HI  = 20;
    localparam int RIROW_LO  = 19;
    localparam int RICOL_HI  = 18;
    localparam int RICOL_LO  = 16;

    // ****************************************************************
    // Table codes
    // ****************************************************************
    localparam logic [2:0] ROW_0      = 3'h0;
    localparam logic [2:0] ROW_1      = 3'h1;
    localparam logic [2:0] ROW_2      = 3'h2;
    localparam logic [2:0] ROW_3      = 3'h3;
    localparam logic [2:0] ROW_4      = 3'h4;
    localparam logic [2:0] ROW_5      = 3'h5;
    localparam logic [2:0] ROW_7      = 3'h7;
    localparam logic [2:0] COL_0      = 3'h0;
    localparam logic [2:0] COL_1      = 3'h1;
    localparam logic [2:0] COL_2      = 3'h2;
    localparam logic [2:0] COL_3      = 3'h3;
    localparam logic [2:0] COL_4      = 3'h4;
    localparam logic [2:0] COL_5      = 3'h5;
    localparam logic [2:0] COL_6      = 3'h6;
    localparam logic [2:0] COL_7      = 3'h7;
    localparam logic [1:0] RIROW_0    = 2'h0;
    localparam logic [1:0] RIROW_EXT  = 2'h3;
    localparam logic [5:0] DEBUG_FUNC = 6'h3F;
    localparam logic [4:0] ZERO_REG   = 5'h00;
    localparam logic [4:0] SHAMT_NOOP = 5'h00;
    localparam logic [4:0] SHAMT_SSNP = 5'h01;
    localparam logic [4:0] SHAMT_BARR = 5'h03;
    localparam logic [4:0] SHAMT_PAUS = 5'h05;
    localparam logic [1:0] COP_FP     = 2'h1;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        K_OTHER        = 3'b000,
        K_REG_CLASS    = 3'b001,
        K_RIMM_CLASS   = 3'b010,
        K_XOR_IMM      = 3'b011,
        K_SECOND_CLASS = 3'b100,
        K_THIRD_CLASS  = 3'b101,
        K_FP_EXT       = 3'b110,
        K_COPROC       = 3'b111
    } iod_kind_t;

    typedef enum logic [4:0] {
        OP_OTHER              = 5'b00000,
        OP_XOR_REG            = 5'b00001,
        OP_XOR_IMM            = 5'b00010,
        OP_SUM_SIGNED         = 5'b00011,
        OP_SUM_WRAPPING       = 5'b00100,
        OP_DIFF_SIGNED        = 5'b00101,
        OP_DIFF_WRAPPING      = 5'b00110,
        OP_AND                = 5'b00111,
        OP_OR                 = 5'b01000,
        OP_SHIFT_LEFT_LOGICAL = 5'b01001,
        OP_NO_OPERATION       = 5'b01010,
        OP_SUPERSCALAR_NOOP   = 5'b01011,
        OP_EXEC_HAZARD_BAR    = 5'b01100,
        OP_PAUSE              = 5'b01101,
        OP_JUMP_REG           = 5'b01110,
        OP_JUMP_REG_BARRIER   = 5'b01111,
        OP_JUMP_LINK_REG      = 5'b10000,
        OP_JUMP_LINK_BARRIER  = 5'b10001,
        OP_BRANCH_BELOW       = 5'b10010,
        OP_BRANCH_AT_ABOVE    = 5'b10011,
        OP_BRANCH_BELOW_LK    = 5'b10100,
        OP_BRANCH_AT_ABOVE_LK = 5'b10101,
        OP_FP_EXTENDED        = 5'b10110,
        OP_DEBUG_BREAK        = 5'b10111,
        OP_EXCEPTION          = 5'b11000
    } iod_op_t;

    typedef struct packed {
        logic          valid;
        iod_op_t       op;
        logic [4:0]    dest;
        logic          wr;
        logic [31:0]   result;
        logic          resv;
        logic          cop_unusable;
        logic [1:0]    cop_num;
    } iod_state_t;

    // ****************************************************************
    // Primary opcode table, row and column
    // ****************************************************************
    function automatic iod_kind_t iod_primary_kind(input logic [2:0] row,
                                                   input logic [2:0] col);
        iod_kind_t k;
        k = K_OTHER;
        case (row)
            ROW_0: begin
                if (col == COL_0) k = K_REG_CLASS;
                else if (col == COL_1) k = K_RIMM_CLASS;
            end
            ROW_1: begin
                if (col == COL_6) k = K_XOR_IMM;
            end
            ROW_2: begin
                if (col == COL_3) k = K_FP_EXT;
                else if (col <= COL_2) k = K_COPROC;
            end
            ROW_3: begin
                if (col == COL_4) k = K_SECOND_CLASS;
                else if (col == COL_7) k = K_THIRD_CLASS;
            end
            default: k = K_OTHER;
        endcase
        return k;
    endfunction : iod_primary_kind

endpackage : iod_pkg

// *** src/iod_path_if.sv ***
/*
 * Carries primary opcode and exclusive OR operands inside the decoder.
 * Assumes all three parties sit in one clock domain.
 */
interface iod_path_if;
    import iod_pkg::*;
    logic [5:0]  primary;
    iod_kind_t   kind;
    logic [31:0] opnd_a;
    logic [31:0] opnd_b;
    logic [15:0] imm;
    logic        use_imm;
    logic [31:0] xres;
    modport lookup (input primary, output kind);
    modport xor_mp (input opnd_a, input opnd_b, input imm, input use_imm, output xres);
    modport core   (output primary, output opnd_a, output opnd_b, output imm,
                    output use_imm, input kind, input xres);
endinterface : iod_path_if

// *** src/iod_primary_lookup.sv ***
/*
 * Primary opcode lookup and exclusive OR datapath.
 * Assumes operands arrive in the same cycle as the word.
 */
module iod_primary_lookup
    import iod_pkg::*;
(
    iod_path_if.lookup lk,
    iod_path_if.xor_mp xu
);
    // ****************************************************************
    // Row and column lookup
    // ****************************************************************
    always_comb begin
        lk.kind = iod_primary_kind(lk.primary[5:3], lk.primary[2:0]);
    end

    // ****************************************************************
    // Bitwise exclusive OR
    // ****************************************************************
    always_comb begin
        if (xu.use_imm) begin
            xu.xres = xu.opnd_a ^ {16'h0000, xu.imm};
        end else begin
            xu.xres = xu.opnd_a ^ xu.opnd_b;
        end
    end
endmodule : iod_primary_lookup

// *** src/integer_opcode_decoder.sv ***
/*
 * Integer opcode decoder: classifies each instruction word, computes
 * exclusive OR results and flags reserved or unusable codes.
 * Assumes fetch supplies a word and its two source register values
 * together, and configuration inputs are static while running.
 */
module iod_integer_opcode_decoder
    import iod_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr_word,
    input  wire logic [31:0] source_a_value,
    input  wire logic [31:0] source_b_value,
    input  wire logic        rev2_impl,
    input  wire logic        fp64_enabled,
    input  wire logic [3:0]  cop_usable,
    input  wire logic        debug_impl,
    input  wire logic        ext_module_impl,
    input  wire logic        second_class_impl,
    output logic             op_valid,
    output iod_op_t          op_code,
    output logic [4:0]       dest_reg,
    output logic             dest_write,
    output logic [31:0]      result,
    output logic             reserved_instr,
    output logic             cop_unusable,
    output logic [1:0]       cop_num
);
    // ****************************************************************
    // Internal paths
    // ****************************************************************
    iod_path_if  path ();
    iod_state_t  st;
    iod_state_t  next_st;
    logic [4:0]  source_b_field;
    logic [4:0]  dest_field;
    logic [4:0]  shift_amount_field;
    logic [2:0]  frow;
    logic [2:0]  fcol;
    logic [1:0]  ri_row;
    logic [2:0]  ri_col;
    logic [1:0]  coproc;

    assign source_b_field     = instr_word[SRCB_HI:SRCB_LO];
    assign dest_field         = instr_word[DEST_HI:DEST_LO];
    assign shift_amount_field = instr_word[SHAMT_HI:SHAMT_LO];
    assign frow               = instr_word[FROW_HI:FROW_LO];
    assign fcol               = instr_word[FCOL_HI:FCOL_LO];
    assign ri_row             = instr_word[RIROW_HI:RIROW_LO];
    assign ri_col             = instr_word[RICOL_HI:RICOL_LO];
    assign coproc             = instr_word[COL_HI - 1:COL_LO];

    assign path.primary = instr_word[ROW_HI:COL_LO];
    assign path.opnd_a  = source_a_value;
    assign path.opnd_b  = source_b_value;
    assign path.imm     = instr_word[IMM_HI:IMM_LO];
    assign path.use_imm = (path.kind == K_XOR_IMM);

    iod_primary_lookup u_lookup (
        .lk (path.lookup),
        .xu (path.xor_mp)
    );

    // ****************************************************************
    // Decode
    // ****************************************************************
    always_comb begin
        next_st              = '0;
        next_st.valid        = instr_valid;
        next_st.op           = OP_OTHER;
        next_st.dest         = ZERO_REG;
        next_st.result       = ZERO_WORD;
        case (path.kind)
            K_REG_CLASS: begin
                case (frow)
                    ROW_0: begin
                        if (fcol == COL_0) begin
                            if (source_b_field == ZERO_REG && dest_field == ZERO_REG) begin
                                if (shift_amount_field == SHAMT_NOOP) begin
                                    next_st.op = OP_NO_OPERATION;
                                end else if (shift_amount_field == SHAMT_SSNP) begin
                                    next_st.op = OP_SUPERSCALAR_NOOP;
                                end else if (shift_amount_field == SHAMT_BARR) begin
                                    next_st.op = rev2_impl ? OP_EXEC_HAZARD_BAR
                                                           : OP_NO_OPERATION;
                                end else if (shift_amount_field == SHAMT_PAUS) begin
                                    if (rev2_impl) begin
                                        next_st.op = OP_PAUSE;
                                    end else begin
                                        next_st.resv = 1'b1;
                                    end
                                end else begin
                                    next_st.op = OP_SHIFT_LEFT_LOGICAL;
                                end
                            end else begin
                                next_st.op   = OP_SHIFT_LEFT_LOGICAL;
                                next_st.dest = dest_field;
                                next_st.wr   = 1'b1;
                            end
                        end
                    end
                    ROW_1: begin
                        if (fcol == COL_0 || fcol == COL_1) begin
                            if (instr_word[HINT_BIT] && !rev2_impl) begin
                                next_st.resv = 1'b1;
                            end else if (fcol == COL_0) begin
                                next_st.op = instr_word[HINT_BIT] ? OP_JUMP_REG_BARRIER
                                                                  : OP_JUMP_REG;
                            end else begin
                                next_st.op = instr_word[HINT_BIT] ? OP_JUMP_LINK_BARRIER
                                                                  : OP_JUMP_LINK_REG;
                                next_st.dest = dest_field;
                                next_st.wr   = 1'b1;
                            end
                        end
                    end
                    ROW_4: begin
                        next_st.dest = dest_field;
                        next_st.wr   = 1'b1;
                        case (fcol)
                            COL_0: next_st.op = OP_SUM_SIGNED;
                            COL_1: next_st.op = OP_SUM_WRAPPING;
                            COL_2: next_st.op = OP_DIFF_SIGNED;
                            COL_3: next_st.op = OP_DIFF_WRAPPING;
                            COL_4: next_st.op = OP_AND;
                            COL_5: next_st.op = OP_OR;
                            COL_6: begin
                                next_st.op     = OP_XOR_REG;
                                next_st.result = path.xres;
                            end
                            default: begin
                                next_st.op   = OP_OTHER;
                                next_st.dest = ZERO_REG;
                                next_st.wr   = 1'b0;
                            end
                        endcase
                    end
                    ROW_5: begin
                        if (fcol == COL_0) next_st.resv = 1'b1;
                    end
                    ROW_7: begin
                        next_st.resv = 1'b1;
                    end
                    default: next_st.op = OP_OTHER;
                endcase
            end
            K_RIMM_CLASS: begin
                if (ri_row == RIROW_0) begin
                    case (ri_col)
                        COL_0:   next_st.op = OP_BRANCH_BELOW;
                        COL_1:   next_st.op = OP_BRANCH_AT_ABOVE;
                        COL_2:   next_st.op = OP_BRANCH_BELOW_LK;
                        COL_3:   next_st.op = OP_BRANCH_AT_ABOVE_LK;
                        default: next_st.op = OP_OTHER;
                    endcase
                end else if (ri_row == RIROW_EXT && ri_col <= COL_3) begin
                    next_st.resv = !ext_module_impl;
                end
            end
            K_XOR_IMM: begin
                next_st.op     = OP_XOR_IMM;
                next_st.result = path.xres;
                next_st.dest   = source_b_field;
                next_st.wr     = 1'b1;
            end
            K_SECOND_CLASS: begin
                if (instr_word[FROW_HI:FCOL_LO] == DEBUG_FUNC) begin
                    if (debug_impl) begin
                        next_st.op = OP_DEBUG_BREAK;
                    end else begin
                        next_st.resv = 1'b1;
                    end
                end else begin
                    next_st.resv = !second_class_impl;
                end
            end
            K_THIRD_CLASS: begin
                next_st.resv = !rev2_impl;
            end
            K_FP_EXT: begin
                next_st.cop_num = COP_FP;
                if (!cop_usable[COP_FP]) begin
                    next_st.cop_unusable = 1'b1;
                end else if (!(rev2_impl && fp64_enabled)) begin
                    next_st.resv = 1'b1;
                end else begin
                    next_st.op = OP_FP_EXTENDED;
                end
            end
            K_COPROC: begin
                next_st.cop_num      = coproc;
                next_st.cop_unusable = !cop_usable[coproc];
            end
            default: next_st.op = OP_OTHER;
        endcase
        if (next_st.resv || next_st.cop_unusable) begin
            next_st.op     = OP_EXCEPTION;
            next_st.wr     = 1'b0;
            next_st.dest   = ZERO_REG;
            next_st.result = ZERO_WORD;
        end
        if (!instr_valid) begin
            next_st = '0;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign op_valid       = st.valid;
    assign op_code        = st.op;
    assign dest_reg       = st.dest;
    assign dest_write     = st.wr;
    assign result         = st.result;
    assign reserved_instr = st.resv;
    assign cop_unusable   = st.cop_unusable;
    assign cop_num        = st.cop_num;

endmodule : iod_integer_opcode_decoder

// *** tb/iod_properties.sv ***
/* Checker for the opcode decoder, bound to its top module.
   Assumes one clock domain and an active-low asynchronous reset. */
module iod_properties
    import iod_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] source_a_value,
    input wire logic [31:0] source_b_value,
    input wire logic        rev2_impl,
    input wire logic        fp64_enabled,
    input wire logic [3:0]  cop_usable,
    input wire logic        op_valid,
    input wire iod_op_t     op_code,
    input wire logic [4:0]  dest_reg,
    input wire logic        dest_write,
    input wire logic [31:0] result,
    input wire logic        reserved_instr,
    input wire logic        cop_unusable,
    input wire logic [1:0]  cop_num
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_answer_next: assert property (instr_valid |=> op_valid)
        else $error("no answer one cycle after a word");
    a_idle_quiet: assert property (!instr_valid |=> !op_valid && !reserved_instr
        && !cop_unusable && result == 32'h0000_0000) else $error("output without word");
    a_xor_register: assert property (instr_valid && instr_word[31:26] == 6'h00
        && instr_word[10:0] == 11'h026 |=> dest_write && dest_reg == $past(instr_word[15:11])
        && result == ($past(source_a_value) ^ $past(source_b_value))) else $error("bad xor");
    a_xor_immediate: assert property (instr_valid && instr_word[31:26] == 6'h0E
        |=> dest_reg == $past(instr_word[20:16])
        && result == ($past(source_a_value) ^ {16'h0000, $past(instr_word[15:0])}))
        else $error("bad immediate xor");
    a_fp_ext_legal: assert property (instr_valid && instr_word[31:26] == 6'h13 && rev2_impl
        && fp64_enabled && cop_usable[1] |=> !reserved_instr && !cop_unusable)
        else $error("legal extended fp code flagged");
    a_fp_ext_unusable: assert property (instr_valid && instr_word[31:26] == 6'h13
        && !cop_usable[1] |=> cop_unusable && cop_num == 2'h1) else $error("no unusable");
    a_third_rev_one: assert property (instr_valid && instr_word[31:26] == 6'h1F
        && !rev2_impl |=> reserved_instr) else $error("third class accepted on rev one");
    a_beyond_level: assert property (instr_valid && instr_word[31:26] == 6'h00
        && instr_word[5:3] == 3'h7 |=> reserved_instr) else $error("row seven accepted");
    a_reserved_inert: assert property (reserved_instr |-> op_code == OP_EXCEPTION
        && !dest_write && result == 32'h0000_0000) else $error("reserved word has effect");
    c_xor: cover property (op_valid && op_code == OP_XOR_REG);
    c_resv: cover property (reserved_instr);
    c_unus: cover property (cop_unusable);
endmodule : iod_properties

bind iod_integer_opcode_decoder iod_properties i_iod_properties (
    .ref_clk(ref_clk), .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
    .source_a_value(source_a_value), .source_b_value(source_b_value),
    .rev2_impl(rev2_impl), .fp64_enabled(fp64_enabled), .cop_usable(cop_usable),
    .op_valid(op_valid), .op_code(op_code), .dest_reg(dest_reg), .dest_write(dest_write),
    .result(result), .reserved_instr(reserved_instr), .cop_unusable(cop_unusable),
    .cop_num(cop_num));

// *** tb/iod_fetch_model.sv ***
/* Fetch stage model: issues words with their register operands.
   Assumes the bench calls put and idle just after a rising edge. */
module iod_fetch_model (
    output logic        instr_valid,
    output logic [31:0] instr_word,
    output logic [31:0] source_a_value,
    output logic [31:0] source_b_value
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] regs [32];
    initial begin
        for (int i = 0; i < 32; i++) regs[i] = {4{8'(i)}} ^ 32'h5A3C_96E1;
        instr_valid = 1'b0;
        instr_word = 32'h0000_0000;
        source_a_value = 32'h0000_0000;
        source_b_value = 32'h0000_0000;
    end
    // Present one word, no obsolete codes issued
    task put(input logic [31:0] w);
        instr_valid <= 1'b1;
        instr_word <= w;
        source_a_value <= regs[w[25:21]];
        source_b_value <= regs[w[20:16]];
    endtask : put
    // Released lines show inverted stale values
    task idle;
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
        source_a_value <= ~source_a_value;
        source_b_value <= ~source_b_value;
    endtask : idle
endmodule : iod_fetch_model

// *** tb/test_integer_opcode_decoder.sv ***
/* Self-checking bench for the opcode decoder.
   Assumes the fetch model and the bound checker. */
module test_integer_opcode_decoder
    import iod_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, nrst, rev2_impl, fp64_enabled, debug_impl, ext_module_impl, second_class_impl;
    logic [3:0]  cop_usable;
    logic        instr_valid, op_valid, dest_write, reserved_instr, cop_unusable;
    logic [31:0] instr_word, source_a_value, source_b_value, result;
    iod_op_t     op_code;
    logic [4:0]  dest_reg;
    logic [1:0]  cop_num;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    iod_fetch_model i_iod_fetch_model (.instr_valid(instr_valid), .instr_word(instr_word),
        .source_a_value(source_a_value), .source_b_value(source_b_value));
    iod_integer_opcode_decoder i_iod_integer_opcode_decoder (.ref_clk(ref_clk), .nrst(nrst),
        .instr_valid(instr_valid), .instr_word(instr_word), .source_a_value(source_a_value),
        .source_b_value(source_b_value), .rev2_impl(rev2_impl), .fp64_enabled(fp64_enabled),
        .cop_usable(cop_usable), .debug_impl(debug_impl), .ext_module_impl(ext_module_impl),
        .second_class_impl(second_class_impl), .op_valid(op_valid), .op_code(op_code),
        .dest_reg(dest_reg), .dest_write(dest_write), .result(result),
        .reserved_instr(reserved_instr), .cop_unusable(cop_unusable), .cop_num(cop_num));
    // ****************************************************************
    // Clock, timeout and shared tasks
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task final_report;
        if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            final_report();
        end
    end
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : cmp
    task cfg(input logic r2, fp, input logic [3:0] cu, input logic dbg, ext, sc);
        @(posedge ref_clk);
        rev2_impl <= r2;
        fp64_enabled <= fp;
        cop_usable <= cu;
        debug_impl <= dbg;
        ext_module_impl <= ext;
        second_class_impl <= sc;
    endtask : cfg
    function automatic logic [31:0] rw(input logic [4:0] s, t, d, sa, input logic [5:0] fn);
        return {6'h00, s, t, d, sa, fn};
    endfunction : rw
    task step(input logic [31:0] w);
        @(posedge ref_clk);
        i_iod_fetch_model.put(w);
    endtask : step
    task fin;
        @(posedge ref_clk);
        i_iod_fetch_model.idle();
        #1;
    endtask : fin
    // One word; OP_OTHER means the operation is not compared
    task dec(input logic [31:0] w, input iod_op_t op, input logic rsv, cu);
        step(w);
        fin();
        cmp("op_valid", 32'h0000_0001, 32'(op_valid));
        if (op != OP_OTHER) cmp("op_code", 32'(op), 32'(op_code));
        cmp("reserved_instr", 32'(rsv), 32'(reserved_instr));
        cmp("cop_unusable", 32'(cu), 32'(cop_unusable));
    endtask : dec
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_xor_pair;
        logic [31:0] ea, eb;
        ea = i_iod_fetch_model.regs[7] ^ i_iod_fetch_model.regs[9];
        eb = i_iod_fetch_model.regs[12] ^ 32'h0000_8001;
        step(rw(5'd7, 5'd9, 5'd3, 5'd0, 6'h26));
        step({6'h0E, 5'd12, 5'd17, 16'h8001});
        #1;
        cmp("result", ea, result);
        cmp("dest_reg", 32'h0000_0003, 32'(dest_reg));
        cmp("dest_write", 32'h0000_0001, 32'(dest_write));
        fin();
        cmp("result", eb, result);
        cmp("dest_reg", 32'h0000_0011, 32'(dest_reg));
        cmp("op_code", 32'(OP_XOR_IMM), 32'(op_code));
    endtask : t_xor_pair
    task t_tables;
        iod_op_t ops [6];
        iod_op_t brs [4];
        ops = '{OP_SUM_SIGNED, OP_SUM_WRAPPING, OP_DIFF_SIGNED, OP_DIFF_WRAPPING, OP_AND, OP_OR};
        for (int i = 0; i < 6; i++) dec(rw(1, 2, 4, 0, 6'h20 + 6'(i)), ops[i], 0, 0);
        brs = '{OP_BRANCH_BELOW, OP_BRANCH_AT_ABOVE, OP_BRANCH_BELOW_LK, OP_BRANCH_AT_ABOVE_LK};
        for (int i = 0; i < 4; i++) dec({6'h01, 5'd2, 5'(i), 16'h0010}, brs[i], 0, 0);
        dec({6'h01, 5'd2, 5'h18, 16'h0000}, OP_EXCEPTION, 1, 0);
        dec(rw(1, 2, 3, 0, 6'h28), OP_EXCEPTION, 1, 0);
        for (int i = 0; i < 8; i++) dec(rw(1, 2, 3, 0, 6'h38 + 6'(i)), OP_EXCEPTION, 1, 0);
    endtask : t_tables
    task t_shift_jump;
        dec(rw(0, 2, 5, 2, 6'h00), OP_SHIFT_LEFT_LOGICAL, 0, 0);
        dec(rw(0, 0, 0, 0, 6'h00), OP_NO_OPERATION, 0, 0);
        dec(rw(0, 0, 0, 1, 6'h00), OP_SUPERSCALAR_NOOP, 0, 0);
        dec(rw(0, 0, 0, 3, 6'h00), OP_EXEC_HAZARD_BAR, 0, 0);
        dec(rw(0, 0, 0, 5, 6'h00), OP_PAUSE, 0, 0);
        dec(rw(4, 0, 0, 0, 6'h08), OP_JUMP_REG, 0, 0);
        dec(rw(4, 0, 0, 5'h10, 6'h08), OP_JUMP_REG_BARRIER, 0, 0);
        dec(rw(4, 0, 31, 0, 6'h09), OP_JUMP_LINK_REG, 0, 0);
        dec(rw(4, 0, 31, 5'h10, 6'h09), OP_JUMP_LINK_BARRIER, 0, 0);
        dec({6'h1F, 26'h0000000}, OP_OTHER, 0, 0);
        cfg(0, 1, 4'hF, 1, 1, 1);
        dec(rw(0, 0, 0, 5, 6'h00), OP_EXCEPTION, 1, 0);
        dec(rw(4, 0, 0, 5'h10, 6'h08), OP_EXCEPTION, 1, 0);
        dec({6'h1F, 26'h0000000}, OP_EXCEPTION, 1, 0);
        dec({6'h13, 26'h0000000}, OP_EXCEPTION, 1, 0);
    endtask : t_shift_jump
    task t_coproc;
        cfg(1, 1, 4'hD, 0, 0, 0);
        dec({6'h13, 26'h0000000}, OP_EXCEPTION, 0, 1);
        cmp("cop_num", 32'h0000_0001, 32'(cop_num));
        dec({6'h1C, 20'h00000, 6'h01}, OP_EXCEPTION, 1, 0);
        dec({6'h1C, 20'h00000, 6'h3F}, OP_EXCEPTION, 1, 0);
        cfg(1, 1, 4'hE, 1, 0, 1);
        dec({6'h10, 26'h0000000}, OP_EXCEPTION, 0, 1);
        cmp("cop_num", 32'h0000_0000, 32'(cop_num));
        dec({6'h13, 26'h0000000}, OP_FP_EXTENDED, 0, 0);
        dec({6'h1C, 20'h00000, 6'h3F}, OP_DEBUG_BREAK, 0, 0);
        dec({6'h1C, 20'h00000, 6'h01}, OP_OTHER, 0, 0);
        cfg(1, 0, 4'hF, 1, 0, 1);
        dec({6'h13, 26'h0000000}, OP_EXCEPTION, 1, 0);
    endtask : t_coproc
    initial begin
        nrst = 1'b0;
        rev2_impl = 1'b1;
        fp64_enabled = 1'b1;
        cop_usable = 4'hF;
        debug_impl = 1'b1;
        ext_module_impl = 1'b0;
        second_class_impl = 1'b1;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        t_xor_pair();
        t_tables();
        t_shift_jump();
        t_coproc();
        final_report();
    end
endmodule : test_integer_opcode_decoder
